/* src/intc_regs_pkg.sv */
package intc_regs_pkg;

    // ********************************************************************
    // Bus geometry
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [7:0] OFS_CONTROL_TWO  = 8'h00;
    localparam logic [7:0] OFS_ENABLE_TWO   = 8'h04;
    localparam logic [7:0] OFS_PRIORITY_0   = 8'h08;
    localparam logic [7:0] OFS_LEVEL_VECTOR = 8'h0C;
    localparam logic [7:0] OFS_EVT_STATUS   = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK     = 8'h14;

    // ********************************************************************
    // Control register fields
    // ********************************************************************
    localparam int CTL_ALT_VT_BIT  = 15;
    localparam int CTL_HOLDOFF_BIT = 14;
    localparam int CTL_POL_MSB     = 4;
    localparam int NUM_EXT         = 5;

    // ********************************************************************
    // Enable register: implemented bits 15,14,12..3
    // ********************************************************************
    localparam logic [15:0] ENABLE_IMPL_MASK = 16'hDFF8;
    localparam logic [15:0] ENABLE_RESET     = 16'h0000;

    // ********************************************************************
    // Priority register: four 3-bit fields, lowest field external 0
    // ********************************************************************
    localparam int          NUM_PRIO_SRC   = 4;
    localparam int          PRIO_W         = 3;
    localparam int          PRIO_STRIDE    = 4;
    localparam logic [15:0] PRIO_IMPL_MASK = 16'h7777;
    localparam logic [15:0] PRIO_RESET     = 16'h4444;
    localparam logic [2:0]  PRIO_DISABLED  = 3'h0;

    // ********************************************************************
    // Level / vector status fields
    // ********************************************************************
    localparam int LVL_LSB = 8;
    localparam int LVL_W   = 4;
    localparam int VEC_W   = 7;

    // Vector index of each prioritised source, minus eight
    localparam logic [6:0] VEC_EXT0   = 7'h00;
    localparam logic [6:0] VEC_INCAP1 = 7'h01;
    localparam logic [6:0] VEC_OUTCMP1 = 7'h02;
    localparam logic [6:0] VEC_TIMER1 = 7'h03;

    // ********************************************************************
    // Event status: bits 4..0 external edges, bit 5 gated request
    // ********************************************************************
    localparam int EVT_W       = 6;
    localparam int EVT_REQ_BIT = 5;

endpackage : intc_regs_pkg

/* src/interrupt_ctrl_registers.sv */
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module interrupt_ctrl_registers (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [15:0] rdata,
    // Core side
    input  wire logic        holdoff_in,
    input  wire logic        core_ack,
    output logic             alt_vector_table_sel,
    output logic      [3:0]  new_cpu_prio_level,
    output logic      [6:0]  pending_vector_index,
    // Peripheral requests
    input  wire logic [4:0]  ext_irq_pin,
    input  wire logic [2:0]  src_req,
    input  wire logic [15:0] periph_req,
    output logic      [15:0] gated_req,
    // Event interrupt
    output logic             irq
);

    // ********************************************************************
    // Register state
    // ********************************************************************
    logic        alt_vt_q;
    logic        holdoff_q;
    logic [4:0]  ext_pol_q;
    logic [15:0] enable_q;
    logic [15:0] prio_q;
    logic [3:0]  level_q;
    logic [6:0]  vector_q;
    logic [5:0]  evt_stat_q;
    logic [5:0]  evt_mask_q;
    logic [15:0] rdata_q;
    logic [15:0] gated_q;
    logic        irq_q;
    logic [4:0]  ext_prev_q;
    logic [4:0]  ext_edge;
    logic [3:0]  pending_q;
    logic [3:0]  pending_set;

    logic wr_ctl;
    logic wr_en;
    logic wr_prio;
    logic wr_stat;
    logic wr_mask;

    assign wr_ctl  = wr_stb && (addr == intc_regs_pkg::OFS_CONTROL_TWO);
    assign wr_en   = wr_stb && (addr == intc_regs_pkg::OFS_ENABLE_TWO);
    assign wr_prio = wr_stb && (addr == intc_regs_pkg::OFS_PRIORITY_0);
    assign wr_stat = wr_stb && (addr == intc_regs_pkg::OFS_EVT_STATUS);
    assign wr_mask = wr_stb && (addr == intc_regs_pkg::OFS_EVT_MASK);

    // ********************************************************************
    // Control register
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            alt_vt_q  <= 1'b0;
            ext_pol_q <= 5'h00;
        end else if (wr_ctl) begin
            alt_vt_q  <= wdata[intc_regs_pkg::CTL_ALT_VT_BIT];
            ext_pol_q <= wdata[intc_regs_pkg::CTL_POL_MSB:0];
        end
    end

    // Status mirror; software writes to it are dropped
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            holdoff_q <= 1'b0;
        end else begin
            holdoff_q <= holdoff_in;
        end
    end

    // ********************************************************************
    // Enable and priority registers
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            enable_q <= intc_regs_pkg::ENABLE_RESET;
        end else if (wr_en) begin
            enable_q <= wdata & intc_regs_pkg::ENABLE_IMPL_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            prio_q <= intc_regs_pkg::PRIO_RESET;
        end else if (wr_prio) begin
            prio_q <= wdata & intc_regs_pkg::PRIO_IMPL_MASK;
        end
    end

    // Each enable bit passes its own request; positions fixed by the mask
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            gated_q <= 16'h0000;
        end else begin
            gated_q <= periph_req & enable_q;
        end
    end

    // ********************************************************************
    // External edge detection
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            // Follows the pin in reset: a line held high gives no false edge
            ext_prev_q <= ext_irq_pin;
        end else begin
            ext_prev_q <= ext_irq_pin;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < intc_regs_pkg::NUM_EXT; gi++) begin : g_edge
            assign ext_edge[gi] = ext_pol_q[gi] ? (ext_prev_q[gi] && !ext_irq_pin[gi])
                                                : (!ext_prev_q[gi] && ext_irq_pin[gi]);
        end
    endgenerate

    // ********************************************************************
    // Pending sources and arbitration
    // ********************************************************************
    // Index 0 external 0, 1 input capture 1, 2 output compare 1, 3 timer 1
    assign pending_set = {src_req[2], src_req[1], src_req[0], ext_edge[0]};

    logic [2:0] win_prio;
    logic [1:0] win_idx;
    logic       win_valid;
    logic [6:0] win_vec;

    always_comb begin
        logic [2:0] fld;
        fld       = 3'h0;
        win_prio  = intc_regs_pkg::PRIO_DISABLED;
        win_idx   = 2'h0;
        win_valid = 1'b0;
        for (int i = 0; i < intc_regs_pkg::NUM_PRIO_SRC; i++) begin
            fld = prio_q[i*intc_regs_pkg::PRIO_STRIDE +: intc_regs_pkg::PRIO_W];
            // Strict compare: ties go to the lower index; zero never wins
            if (pending_q[i] && (fld > win_prio)) begin
                win_prio  = fld;
                win_idx   = i[1:0];
                win_valid = 1'b1;
            end
        end
    end

    always_comb begin
        unique case (win_idx)
            2'h0: win_vec = intc_regs_pkg::VEC_EXT0;
            2'h1: win_vec = intc_regs_pkg::VEC_INCAP1;
            2'h2: win_vec = intc_regs_pkg::VEC_OUTCMP1;
            2'h3: win_vec = intc_regs_pkg::VEC_TIMER1;
        endcase
    end

    // Acknowledge retires the reported winner; a new request wins over it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pending_q <= 4'h0;
        end else begin
            for (int i = 0; i < intc_regs_pkg::NUM_PRIO_SRC; i++) begin
                if (pending_set[i]) begin
                    pending_q[i] <= 1'b1;
                end else if (core_ack && level_q != 4'h0 && vector_q == win_vec && win_idx == i[1:0]) begin
                    pending_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            level_q  <= 4'h0;
            vector_q <= 7'h00;
        end else if (win_valid) begin
            level_q  <= {1'b0, win_prio};
            vector_q <= win_vec;
        end else begin
            level_q  <= 4'h0;
            vector_q <= 7'h00;
        end
    end

    // ********************************************************************
    // Event status and mask
    // ********************************************************************
    logic [5:0] evt_in;
    assign evt_in = {|gated_q, ext_edge};

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            evt_stat_q <= 6'h00;
        end else begin
            // Set beats a same-cycle write-one clear
            evt_stat_q <= (evt_stat_q & ~(wr_stat ? wdata[5:0] : 6'h00)) | evt_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            evt_mask_q <= 6'h00;
        end else if (wr_mask) begin
            evt_mask_q <= wdata[5:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_stat_q & evt_mask_q);
        end
    end

    // ********************************************************************
    // Read port
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else if (rd_stb) begin
            unique case (addr)
                intc_regs_pkg::OFS_CONTROL_TWO:
                    rdata_q <= {alt_vt_q, holdoff_q, 9'h000, ext_pol_q};
                intc_regs_pkg::OFS_ENABLE_TWO:   rdata_q <= enable_q;
                intc_regs_pkg::OFS_PRIORITY_0:   rdata_q <= prio_q;
                intc_regs_pkg::OFS_LEVEL_VECTOR:
                    rdata_q <= {4'h0, level_q, 1'b0, vector_q};
                intc_regs_pkg::OFS_EVT_STATUS:   rdata_q <= {10'h000, evt_stat_q};
                intc_regs_pkg::OFS_EVT_MASK:     rdata_q <= {10'h000, evt_mask_q};
                default:                         rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign rdata                = rdata_q;
    assign alt_vector_table_sel = alt_vt_q;
    assign new_cpu_prio_level   = level_q;
    assign pending_vector_index = vector_q;
    assign gated_req            = gated_q;
    assign irq                  = irq_q;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_alt_vt;
        wr_ctl |=> alt_vector_table_sel == $past(wdata[15]);
    endproperty
    a_alt_vt: assert property (p_alt_vt) else $error("alt table select not written");

    property p_holdoff_read;
        rd_stb && addr == intc_regs_pkg::OFS_CONTROL_TWO ##1 1'b1 |-> rdata[14] == $past(holdoff_in, 2);
    endproperty
    a_holdoff_read: assert property (p_holdoff_read) else $error("hold-off status misread");

    property p_neg_edge;
        ext_pol_q[0] && ext_prev_q[0] && !ext_irq_pin[0] |=> evt_stat_q[0];
    endproperty
    a_neg_edge: assert property (p_neg_edge) else $error("negative edge missed");

    property p_pos_ignored;
        ext_pol_q[0] && !ext_prev_q[0] && ext_irq_pin[0] |=> !$rose(pending_q[0]);
    endproperty
    a_pos_ignored: assert property (p_pos_ignored) else $error("wrong edge taken");

    property p_ctl_zero;
        rd_stb && addr == intc_regs_pkg::OFS_CONTROL_TWO |=> rdata[13:5] == 9'h000;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("reserved control bits nonzero");

    property p_stat_zero;
        rd_stb |=> (rdata[15:12] == 4'h0 && !rdata[7]) || $past(addr) != intc_regs_pkg::OFS_LEVEL_VECTOR;
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("reserved status bits nonzero");

    property p_gate;
        ##1 gated_req == ($past(periph_req) & $past(enable_q) & 16'hDFF8);
    endproperty
    a_gate: assert property (p_gate) else $error("request gating wrong");

    property p_disabled;
        pending_q[3] && (prio_q[14:12] == 3'h0) && (pending_q[2:0] == 3'h0)
            |=> new_cpu_prio_level == 4'h0;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled source selected");

    property p_winner_max;
        win_valid |=> new_cpu_prio_level >= {1'b0, $past(prio_q[2:0])} || !$past(pending_q[0]);
    endproperty
    a_winner_max: assert property (p_winner_max) else $error("lower priority chosen");

    property p_prio_rw;
        wr_prio ##1 rd_stb && addr == intc_regs_pkg::OFS_PRIORITY_0 && !wr_stb
            |=> rdata == ($past(wdata, 2) & 16'h7777);
    endproperty
    a_prio_rw: assert property (p_prio_rw) else $error("priority field readback wrong");

    property p_prio_reset;
        $rose(reset_n) |-> prio_q == 16'h4444;
    endproperty
    a_prio_reset: assert property (p_prio_reset) else $error("priority reset value wrong");

    property p_vec_ext0;
        win_valid && win_idx == 2'h0 |=> pending_vector_index == 7'h00 && new_cpu_prio_level != 4'h0;
    endproperty
    a_vec_ext0: assert property (p_vec_ext0) else $error("vector or level not updated");

endmodule : interrupt_ctrl_registers

/* testbench/core_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Core model: takes the reported interrupt after a set delay
// ************************************************************
module core_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Bench controls
    input  wire logic       ack_on,
    input  wire logic [3:0] ack_delay,
    input  wire logic       holdoff_on,
    // Controller side
    input  wire logic [3:0] new_cpu_prio_level,
    output logic            holdoff_in,
    output logic            core_ack
);
    logic [3:0] wait_q;
    logic [1:0] cool_q;

    assign holdoff_in = holdoff_on;

    // Pause after each take: the old winner stays visible two more cycles
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wait_q   <= 4'h0;
            cool_q   <= 2'h0;
            core_ack <= 1'b0;
        end else begin
            core_ack <= 1'b0;
            if (cool_q != 2'h0) begin
                cool_q <= cool_q - 2'h1;
            end else if (ack_on && new_cpu_prio_level != 4'h0) begin
                if (wait_q == ack_delay) begin
                    core_ack <= 1'b1;
                    wait_q   <= 4'h0;
                    cool_q   <= 2'h3;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule : core_model

/* testbench/interrupt_ctrl_registers_tb.sv */
`timescale 1ns/1ps
module interrupt_ctrl_registers_tb;
    logic        core_clk;
    logic        reset_n;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [15:0] rdata;
    logic        holdoff_in;
    logic        core_ack;
    logic        alt_vector_table_sel;
    logic [3:0]  new_cpu_prio_level;
    logic [6:0]  pending_vector_index;
    logic [4:0]  ext_irq_pin;
    logic [2:0]  src_req;
    logic [15:0] periph_req;
    logic [15:0] gated_req;
    logic        irq;
    logic        ack_on;
    logic [3:0]  ack_delay;
    logic        holdoff_on;
    logic [6:0]  taken_q[$];
    int          fails;
    int          comparisons;
    int          cycles;
    localparam int LIMIT = 3000;

    interrupt_ctrl_registers dut (.core_clk, .reset_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .holdoff_in,
        .core_ack, .alt_vector_table_sel, .new_cpu_prio_level, .pending_vector_index, .ext_irq_pin, .src_req,
        .periph_req, .gated_req, .irq);
    core_model core (.core_clk, .reset_n, .ack_on, .ack_delay, .holdoff_on, .new_cpu_prio_level, .holdoff_in,
        .core_ack);

    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        // A following write raises the strobe in a later time step
        #1;
    endtask : wr

    // Read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        check(rdata, exp, nm);
    endtask : rd

    task automatic lv(input logic [3:0] l, input logic [6:0] v);
        check({5'h00, new_cpu_prio_level, pending_vector_index}, {5'h00, l, v}, "level_vector");
    endtask : lv

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    always @(posedge core_clk) begin
        if (core_ack === 1'b1) begin
            taken_q.push_back(pending_vector_index);
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            final_report();
        end
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        reset_n = 1'b0; addr = 8'h00; wdata = 16'h0000; wr_stb = 1'b0; rd_stb = 1'b0;
        ext_irq_pin = 5'h00; src_req = 3'h0; periph_req = 16'h0000;
        ack_on = 1'b0; ack_delay = 4'h0; holdoff_on = 1'b0;
        cyc(8);
        reset_n <= 1'b1;
        cyc(1);
        rd(8'h00, 16'h0000, "control");
        rd(8'h04, 16'h0000, "enable");
        rd(8'h08, 16'h4444, "priority");
        rd(8'h0C, 16'h0000, "level_reg");
        rd(8'h10, 16'h0000, "status");
        rd(8'h14, 16'h0000, "mask");
        rd(8'h20, 16'h0000, "unmapped");
        wr(8'h0C, 16'hFFFF);
        rd(8'h0C, 16'h0000, "level_ro");
        $display("test reset done");

        wr(8'h00, 16'hFFFF);
        rd(8'h00, 16'h801F, "control_all");
        check({15'h0000, alt_vector_table_sel}, 16'h0001, "alt_sel");
        holdoff_on <= 1'b1;
        cyc(2);
        rd(8'h00, 16'hC01F, "holdoff_set");
        holdoff_on <= 1'b0;
        wr(8'h00, 16'h0000);
        cyc(2);
        rd(8'h00, 16'h0000, "control_clr");
        check({15'h0000, alt_vector_table_sel}, 16'h0000, "alt_sel");
        $display("test control done");

        wr(8'h04, 16'hFFFF);
        rd(8'h04, 16'hDFF8, "enable_all");
        periph_req <= 16'hFFFF;
        for (int i = 0; i < 16; i++) begin
            wr(8'h04, 16'h0001 << i);
            cyc(2);
            check(gated_req, (16'h0001 << i) & 16'hDFF8, "gated");
        end
        wr(8'h04, 16'h0000);
        periph_req <= 16'h0000;
        wr(8'h08, 16'hFFFF);
        rd(8'h08, 16'h7777, "prio_all");
        $display("test fields done");

        wr(8'h10, 16'h003F);
        wr(8'h08, 16'h1237);
        ext_irq_pin <= 5'h01;
        src_req     <= 3'h7;
        cyc(1);
        src_req <= 3'h0;
        cyc(5);
        lv(4'h7, 7'h00);
        rd(8'h0C, 16'h0700, "level_reg");
        taken_q.delete();
        ack_on    <= 1'b1;
        ack_delay <= 4'h2;
        cyc(40);
        check(16'(taken_q.size()), 16'h0004, "takes");
        for (int i = 0; i < 4; i++) begin
            check({9'h000, taken_q[i]}, 16'(i), "taken_vector");
        end
        lv(4'h0, 7'h00);
        $display("test arbitration done");

        ack_on <= 1'b0;
        wr(8'h08, 16'h0444);
        src_req <= 3'h4;
        cyc(1);
        src_req <= 3'h0;
        cyc(5);
        lv(4'h0, 7'h00);
        src_req <= 3'h1;
        cyc(1);
        src_req <= 3'h0;
        cyc(5);
        lv(4'h4, 7'h01);
        ack_on    <= 1'b1;
        ack_delay <= 4'h0;
        cyc(8);
        lv(4'h0, 7'h00);
        ack_on      <= 1'b0;
        ext_irq_pin <= 5'h00;
        cyc(4);
        lv(4'h0, 7'h00);
        wr(8'h00, 16'h0001);
        ext_irq_pin <= 5'h01;
        cyc(4);
        lv(4'h0, 7'h00);
        ext_irq_pin <= 5'h00;
        cyc(4);
        lv(4'h4, 7'h00);
        ack_on <= 1'b1;
        cyc(8);
        ack_on <= 1'b0;
        $display("test disable and polarity done");

        // Events: sticky status, mask, level interrupt
        wr(8'h14, 16'h0000);
        wr(8'h10, 16'h003F);
        ext_irq_pin <= 5'h04;
        cyc(4);
        rd(8'h10, 16'h0004, "status_edge");
        check({15'h0000, irq}, 16'h0000, "irq_masked");
        wr(8'h14, 16'h0004);
        cyc(2);
        check({15'h0000, irq}, 16'h0001, "irq_on");
        wr(8'h10, 16'h0004);
        cyc(2);
        check({15'h0000, irq}, 16'h0000, "irq_cleared");
        rd(8'h10, 16'h0000, "status_clr");
        wr(8'h04, 16'h8000);
        periph_req <= 16'h8000;
        wr(8'h14, 16'h0020);
        cyc(3);
        check({15'h0000, irq}, 16'h0001, "irq_gated");
        periph_req <= 16'h0000;
        cyc(2);
        wr(8'h10, 16'h0020);
        cyc(2);
        check({15'h0000, irq}, 16'h0000, "irq_gated_clr");
        $display("test events done");
        final_report();
    end
endmodule : interrupt_ctrl_registers_tb
